// file: eec_ctrl.sv
// Bus controller that drives a two-wire serial EEPROM
// How it works
// - SDA data bits change only while SCL low
// - Start is SDA fall, SCL high
// - Recovery: up to nine clocks, then start once SDA is high, else timeout
// - Address word begins with fixed pattern
// - Eighth address bit selects read/write
// - Byte write: address, two bytes, data, stop
// - Page write up to 63 more bytes
// - Current read ends with nack, stop
// - Random read: dummy write, repeated start
// - Sequential read: ack continues, nack ends
module eec_ctrl
  import eec_pkg::*;
#(
  parameter int QTR_CYC_P  = QTR_CYC,
  parameter int PROG_CYC_P = PROG_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire eec_cmd_s    cmd_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [7:0]  wr_data_i,
  output logic             rd_valid_o,
  output logic [7:0]       rd_data_o,
  output logic             done_o,
  output eec_status_s      status_o,
  output logic             wp_o,
  output logic             scl_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o
);

  // ************************************************************
  // Elaboration checks and declarations
  // ************************************************************
  if (QTR_CYC_P < 2) begin : g_bad_qtr
    $error("QTR_CYC_P must be at least 2");
  end
  if (PROG_CYC_P < 2) begin : g_bad_prog
    $error("PROG_CYC_P must be at least 2");
  end

  localparam int QW = $clog2(QTR_CYC_P + 1);
  localparam int PW = $clog2(PROG_CYC_P + 1);
  localparam logic [QW-1:0] QTR_LOAD = QW'(QTR_CYC_P - 1);
  localparam logic [PW-1:0] PROG_END = PW'(PROG_CYC_P - 1);

  eec_state_e    state_reg;
  eec_kind_e     kind_reg;
  eec_cmd_s      cmd_reg;
  eec_status_s   stat_reg;
  logic [1:0]    phase_reg;
  logic [3:0]    bit_reg;
  logic [7:0]    shift_reg;
  logic [6:0]    cnt_reg;
  logic          samp_reg;
  logic          poll_reg;
  logic          rstart_reg;
  logic [QW-1:0] qcnt_reg;
  logic [PW-1:0] tmo_reg;
  logic          tmo_hit_reg;
  logic          sda_s;
  logic          tick;
  logic          scl_next;
  logic          rel_next;
  logic          tx_bit;
  logic          ack_ok;

  // ************************************************************
  // Pin input and quarter-bit timer
  // ************************************************************
  eec_sync #(.W(1), .RST_VAL(1'b1)) u_sda_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    (sda_i),
    .sync_o     (sda_s)
  );

  assign tick = (qcnt_reg == '0);

  // Free-running quarter period divider makes the bus clock
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= tick ? QTR_LOAD : qcnt_reg - QW'(1);
    end
  end

  // Bound on acknowledge polling while the device programs
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tmo_reg     <= '0;
      tmo_hit_reg <= 1'b0;
    end else if (!poll_reg) begin
      tmo_reg     <= '0;
      tmo_hit_reg <= 1'b0;
    end else if (tmo_reg == PROG_END) begin
      tmo_hit_reg <= 1'b1;
    end else begin
      tmo_reg <= tmo_reg + PW'(1);
    end
  end

  // ************************************************************
  // Pin levels per state and quarter
  // ************************************************************
  // Bit value: data MSB first, ack slot released on send,
  // acknowledged on read unless this is the last byte
  assign tx_bit = (bit_reg != ACK_BIT) ?
                  ((kind_reg == K_RDATA) ? 1'b1 : shift_reg[7]) :
                  ((kind_reg == K_RDATA) ? (cnt_reg == '0) : 1'b1);

  // Bits move SDA in quarter 1, a quarter after SCL falls; start and stop preset it in quarter 1 and move it in quarter 3
  always_comb begin
    scl_next = 1'b1;
    rel_next = sda_oe_n_o;
    case (state_reg)
      S_START: begin
        scl_next = phase_reg[1];
        if (phase_reg == PH_SETUP) rel_next = 1'b1;
        if (phase_reg == PH_LAST)  rel_next = 1'b0;
      end
      S_STOP: begin
        scl_next = phase_reg[1];
        if (phase_reg == PH_SETUP) rel_next = 1'b0;
        if (phase_reg == PH_LAST)  rel_next = 1'b1;
      end
      S_BYTE: begin
        scl_next = phase_reg[1];
        if (phase_reg == PH_SETUP) rel_next = tx_bit;
      end
      S_RECOV: begin
        scl_next = phase_reg[1];
        rel_next = 1'b1;
      end
      S_HOLD: begin
        scl_next = 1'b0;
      end
      default: begin
        scl_next = 1'b1;
        rel_next = 1'b1;
      end
    endcase
  end

  // Registered pin drive; SDA is open drain, low when enabled
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_o      <= 1'b1;
      sda_oe_n_o <= 1'b1;
      sda_o      <= 1'b0;
      wp_o       <= 1'b1;
    end else begin
      scl_o      <= scl_next;
      sda_oe_n_o <= rel_next;
      sda_o      <= 1'b0;
      wp_o       <= !(state_reg != S_IDLE && cmd_reg.op == OP_WRITE);
    end
  end

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  assign ack_ok      = !samp_reg;
  assign cmd_ready_o = (state_reg == S_IDLE);
  assign wr_ready_o  = (state_reg == S_HOLD);
  assign status_o    = stat_reg;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg  <= S_IDLE;
      kind_reg   <= K_DEV;
      cmd_reg    <= '0;
      stat_reg   <= '0;
      phase_reg  <= '0;
      bit_reg    <= '0;
      shift_reg  <= '0;
      cnt_reg    <= '0;
      samp_reg   <= 1'b1;
      poll_reg   <= 1'b0;
      rstart_reg <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
      done_o     <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      done_o     <= 1'b0;
      if (tick && state_reg != S_IDLE && state_reg != S_HOLD &&
          state_reg != S_DONE) begin
        phase_reg <= phase_reg + 2'h1;
        if (phase_reg == PH_SAMPLE) samp_reg <= sda_s;
      end
      case (state_reg)
        S_IDLE: if (cmd_valid_i) begin
          cmd_reg    <= cmd_i;
          cnt_reg    <= (cmd_i.op == OP_WRITE) ?
                        (cmd_i.count & PAGE_LAST) : cmd_i.count;
          stat_reg   <= '0;
          poll_reg   <= 1'b0;
          rstart_reg <= 1'b0;
          phase_reg  <= '0;
          bit_reg    <= '0;
          state_reg  <= (cmd_i.op == OP_RECOVER) ? S_RECOV : S_START;
        end
        S_START: if (tick && phase_reg == PH_LAST) begin
          bit_reg   <= '0;
          state_reg <= S_BYTE;
          if (cmd_reg.op == OP_RECOVER) begin
            state_reg <= S_STOP;
          end else if (poll_reg) begin
            kind_reg  <= K_POLL;
            shift_reg <= {DEV_FIXED, cmd_reg.strap, DIR_WRITE};
          end else if (cmd_reg.op == OP_READ_CUR || rstart_reg) begin
            kind_reg  <= K_RDEV;
            shift_reg <= {DEV_FIXED, cmd_reg.strap, DIR_READ};
          end else begin
            kind_reg  <= K_DEV;
            shift_reg <= {DEV_FIXED, cmd_reg.strap, DIR_WRITE};
          end
        end
        S_BYTE: if (tick && phase_reg == PH_LAST) begin
          if (bit_reg != ACK_BIT) begin
            shift_reg <= {shift_reg[6:0], samp_reg};
            bit_reg   <= bit_reg + 4'h1;
          end else begin
            bit_reg <= '0;
            case (kind_reg)
              K_DEV, K_AHI, K_ALO, K_DATA, K_RDEV: begin
                if (!ack_ok) begin
                  stat_reg.nack <= 1'b1;
                  state_reg     <= S_STOP;
                end else if (kind_reg == K_DEV) begin
                  kind_reg  <= K_AHI;
                  shift_reg <= cmd_reg.waddr[15:8];
                end else if (kind_reg == K_AHI) begin
                  kind_reg  <= K_ALO;
                  shift_reg <= cmd_reg.waddr[7:0];
                end else if (kind_reg == K_ALO) begin
                  if (cmd_reg.op == OP_READ_RAND) begin
                    rstart_reg <= 1'b1;
                    state_reg  <= S_START;
                  end else begin
                    kind_reg  <= K_DATA;
                    state_reg <= S_HOLD;
                  end
                end else if (kind_reg == K_DATA) begin
                  if (cnt_reg == '0) begin
                    poll_reg  <= 1'b1;
                    state_reg <= S_STOP;
                  end else begin
                    cnt_reg   <= cnt_reg - 7'h1;
                    state_reg <= S_HOLD;
                  end
                end else begin
                  kind_reg <= K_RDATA;
                end
              end
              K_RDATA: begin
                rd_data_o  <= shift_reg;
                rd_valid_o <= 1'b1;
                if (cnt_reg == '0) begin
                  state_reg <= S_STOP;
                end else begin
                  cnt_reg <= cnt_reg - 7'h1;
                end
              end
              default: begin
                if (ack_ok) poll_reg <= 1'b0;
                state_reg <= S_STOP;
              end
            endcase
          end
        end
        S_HOLD: if (wr_valid_i) begin
          shift_reg <= wr_data_i;
          bit_reg   <= '0;
          phase_reg <= '0;
          state_reg <= S_BYTE;
        end
        S_STOP: if (tick && phase_reg == PH_LAST) begin
          if (poll_reg && !tmo_hit_reg) begin
            state_reg <= S_START;
          end else begin
            stat_reg.timeout <= poll_reg;
            poll_reg         <= 1'b0;
            state_reg        <= S_DONE;
          end
        end
        S_RECOV: if (tick && phase_reg == PH_LAST) begin
          bit_reg <= bit_reg + 4'h1;
          if (samp_reg) begin
            state_reg <= S_START;
          end else if (bit_reg == RECOV_CLOCKS - 4'h1) begin
            stat_reg.timeout <= 1'b1;
            state_reg        <= S_DONE;
          end
        end
        S_DONE: begin
          done_o    <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_SDA_STEADY_HIGH: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (scl_o && $past(scl_o) && state_reg == S_BYTE &&
     $past(state_reg) == S_BYTE) |-> $stable(sda_oe_n_o))
    else $error("SDA moved while SCL high in a byte");
  AST_RISE_ONLY_STOP: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    ($rose(sda_oe_n_o) && scl_o) |-> $past(state_reg) == S_STOP)
    else $error("SDA rose with SCL high outside stop");
  AST_FALL_ONLY_START: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    ($fell(sda_oe_n_o) && scl_o) |-> $past(state_reg) == S_START)
    else $error("SDA fell with SCL high outside start");
  AST_RECOV_NINE: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    state_reg == S_RECOV |-> bit_reg < RECOV_CLOCKS)
    else $error("Recovery ran past nine clocks");
  AST_DEV_PATTERN: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (state_reg == S_BYTE && bit_reg == '0 &&
     (kind_reg == K_DEV || kind_reg == K_RDEV || kind_reg == K_POLL))
    |-> shift_reg[7:1] == {DEV_FIXED, cmd_reg.strap})
    else $error("Device address word has wrong fixed part");
  AST_DIR_BIT: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (state_reg == S_BYTE && bit_reg == '0 && kind_reg != K_DATA &&
     kind_reg != K_AHI && kind_reg != K_ALO && kind_reg != K_RDATA)
    |-> shift_reg[0] == (kind_reg == K_RDEV))
    else $error("Direction bit does not match operation");
  AST_STOP_AFTER_LAST: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    ($past(state_reg) == S_BYTE && $past(kind_reg) == K_DATA &&
     $past(cnt_reg) == '0 && state_reg != S_BYTE)
    |-> state_reg == S_STOP)
    else $error("Last written byte not followed by stop");
  AST_PAGE_BOUND: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    state_reg == S_HOLD |-> (cnt_reg <= PAGE_LAST &&
                             cmd_reg.op == OP_WRITE))
    else $error("Page write longer than one page");
  AST_NACK_LAST: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (state_reg == S_BYTE && kind_reg == K_RDATA && bit_reg == ACK_BIT &&
     cnt_reg == '0 && phase_reg[1]) |-> sda_oe_n_o)
    else $error("Last read byte was acknowledged");
  AST_ACK_MORE: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (state_reg == S_BYTE && kind_reg == K_RDATA && bit_reg == ACK_BIT &&
     cnt_reg != '0 && phase_reg[1]) |-> !sda_oe_n_o)
    else $error("Read byte with more to come not acknowledged");
  AST_RSTART_AFTER_ADDR: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    $rose(rstart_reg) |-> (state_reg == S_START &&
                           $past(kind_reg) == K_ALO))
    else $error("Repeated start not after word address");

endmodule : eec_ctrl

// file: eec_dev_model.sv
// Behavioural two-wire serial EEPROM that answers the bus controller
module eec_dev_model (
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        wp_i,
  input  wire logic [1:0]  strap_i,
  input  wire logic [15:0] prog_ns_i,
  output logic             pull_o
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] IDLE = 3'h0;
  localparam logic [2:0] DEV  = 3'h1;
  localparam logic [2:0] AHI  = 3'h2;
  localparam logic [2:0] ALO  = 3'h3;
  localparam logic [2:0] WDAT = 3'h4;
  localparam logic [2:0] RDAT = 3'h5;

  logic [7:0]  mem [0:32767];
  logic [7:0]  sh;
  logic [7:0]  ahi;
  logic [7:0]  rbyte;
  logic [14:0] addr;
  logic [3:0]  cnt;
  logic [2:0]  st;
  logic        mack;
  logic        busy;
  logic        wrote;

  // ************************************************************
  // Bus conditions
  // ************************************************************
  // Power-up in standby, array preset to a known pattern
  initial begin
    st = IDLE;
    cnt = 4'h0;
    pull_o = 1'b0;
    busy = 1'b0;
    wrote = 1'b0;
    mack = 1'b0;
    addr = 15'h0000;
    for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'hC3;
  end

  // Start, ignored while programming
  always @(negedge sda_i) begin
    if (scl_i === 1'b1 && !busy) begin
      st = DEV;
      cnt = 4'h0;
    end
  end

  // Stop ends the transfer and launches any program cycle
  always @(posedge sda_i) begin
    if (scl_i === 1'b1 && !busy) begin
      st = IDLE;
      cnt = 4'h0;
      busy = wrote;
      wrote = 1'b0;
    end
  end

  // Program timer; the part stays deaf until it runs out
  always @(posedge busy) begin
    #(prog_ns_i);
    busy = 1'b0;
  end

  // ************************************************************
  // Bit engine
  // ************************************************************
  // Sample data bits, then the controller's ninth bit
  always @(posedge scl_i) begin
    if (st != IDLE) begin
      if (cnt < 4'h8) sh = {sh[6:0], sda_i};
      else mack = !sda_i;
      cnt = cnt + 4'h1;
    end
  end

  // Act on whole words and drive SDA while SCL is low
  always @(negedge scl_i) begin
    if (st == IDLE) pull_o = 1'b0;
    else if (cnt == 4'h8) begin
      pull_o = 1'b1;
      case (st)
        DEV: begin
          pull_o = (sh[7:3] == 5'h14) && (sh[2:1] == strap_i);
          st = !pull_o ? IDLE : (sh[0] ? RDAT : AHI);
        end
        AHI: begin
          ahi = sh;
          st = ALO;
        end
        ALO: begin
          addr = {ahi[6:0], sh};
          st = WDAT;
        end
        WDAT: begin
          if (!wp_i) mem[addr] = sh;
          wrote = wrote | !wp_i;
          addr[5:0] = addr[5:0] + 6'h01;
        end
        default: pull_o = 1'b0;
      endcase
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      pull_o = 1'b0;
      if (st == RDAT && mack) begin
        rbyte = mem[addr];
        addr = addr + 15'h0001;
        pull_o = !rbyte[7];
      end else if (st == RDAT) st = IDLE;
    end else if (st == RDAT) pull_o = !rbyte[7 - cnt];
  end
endmodule : eec_dev_model

// file: eec_note_end.sv
// Spare unit: holds no logic of the bus controller

// file: eec_pkg.sv
// Constants and types for the serial EEPROM bus controller
package eec_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 4;          // Core clock period
  localparam int SCL_PERIOD_NS = 2500;       // Bus clock period
  // Quarter of a bus clock in core cycles, rounded down
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int PROG_TIME_NS  = 20000000;   // Longest internal program
  localparam int PROG_CYC      = PROG_TIME_NS / CLK_PERIOD_NS;

  // ************************************************************
  // Protocol constants
  // ************************************************************
  localparam logic [4:0] DEV_FIXED    = 5'h14;  // 1010 then 0
  localparam logic [3:0] ACK_BIT      = 4'h8;   // Ninth bit slot
  localparam logic [3:0] RECOV_CLOCKS = 4'h9;   // Recovery clock count
  localparam logic [6:0] PAGE_LAST    = 7'h3F;  // Bytes in page less one
  localparam logic [1:0] PH_LAST      = 2'h3;
  localparam logic [1:0] PH_SAMPLE    = 2'h2;
  localparam logic [1:0] PH_SETUP     = 2'h1;
  localparam logic       DIR_READ     = 1'b1;
  localparam logic       DIR_WRITE    = 1'b0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    OP_WRITE     = 2'h0,
    OP_READ_CUR  = 2'h1,
    OP_READ_RAND = 2'h2,
    OP_RECOVER   = 2'h3
  } eec_op_e;

  typedef enum logic [2:0] {
    K_DEV   = 3'h0,
    K_AHI   = 3'h1,
    K_ALO   = 3'h2,
    K_DATA  = 3'h3,
    K_RDEV  = 3'h4,
    K_RDATA = 3'h5,
    K_POLL  = 3'h6
  } eec_kind_e;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_START = 7'h02,
    S_BYTE  = 7'h04,
    S_HOLD  = 7'h08,
    S_STOP  = 7'h10,
    S_RECOV = 7'h20,
    S_DONE  = 7'h40
  } eec_state_e;

  typedef struct packed {
    eec_op_e     op;
    logic [1:0]  strap;   // strap_select_hi, strap_select_lo
    logic [15:0] waddr;
    logic [6:0]  count;   // Bytes to move less one
  } eec_cmd_s;

  typedef struct packed {
    logic nack;
    logic timeout;
  } eec_status_s;

endpackage : eec_pkg

// file: eec_sync.sv
// Two flip-flop synchroniser for pin inputs
module eec_sync
  import eec_pkg::*;
#(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : eec_sync

// file: tb_top.sv
// Self-checking bench for the serial EEPROM bus controller
module tb_top
  import eec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        resetn;
  logic        cmd_valid;
  eec_cmd_s    cmd;
  logic        wr_valid;
  logic [7:0]  wr_data;
  logic        cmd_ready;
  logic        wr_ready;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        done;
  eec_status_s status;
  logic        wp;
  logic        scl;
  logic        sda_o;
  logic        sda_oe_n;
  logic [1:0]  strap;
  logic [15:0] prog_ns;
  logic        dev_pull;
  logic        stuck;
  wire         sda;
  int          miscompares = 0;
  int          compares = 0;
  logic [7:0]  wq [$];
  logic [7:0]  rq [$];

  // Open-drain SDA with pull-up: low if any party pulls
  assign sda = !((!sda_oe_n && !sda_o) || dev_pull || stuck);

  eec_ctrl #(.QTR_CYC_P(4), .PROG_CYC_P(2000)) eec_ctrl_i (
    .core_clk_i(clk), .resetn_i(resetn), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_i(cmd), .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready), .wr_data_i(wr_data), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .done_o(done), .status_o(status), .wp_o(wp),
    .scl_o(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));

  eec_dev_model eec_dev_model_i (
    .scl_i(scl), .sda_i(sda), .wp_i(wp), .strap_i(strap),
    .prog_ns_i(prog_ns), .pull_o(dev_pull));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // One command: feed write bytes, collect read bytes, wait for done
  task automatic run(input eec_op_e op, input logic [1:0] sel,
                     input logic [15:0] wa, input logic [6:0] n);
    bit fin;
    fin = 1'b0;
    rq = {};
    @(negedge clk);
    for (int k = 0; k < 1000 && cmd_ready !== 1'b1; k++) @(negedge clk);
    cmd = '{op, sel, wa, n};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (int k = 0; k < 40000 && !fin; k++) begin
      @(negedge clk);
      if (wr_valid) wr_valid = 1'b0;
      else if (wr_ready === 1'b1) begin
        wr_valid = 1'b1;
        wr_data = wq.pop_front();
      end
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      fin = (done === 1'b1);
    end
    check(fin, 16'h0001);
  endtask : run

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Full page from mid-page offset wraps inside its page
  task automatic t_page();
    for (int i = 0; i < 64; i++) wq.push_back(8'(i) ^ 8'h5A);
    run(OP_WRITE, 2'h2, 16'h8250, 7'h7F);
    check(status, 16'h0000);
    for (int i = 0; i < 64; i++)
      check(eec_dev_model_i.mem[15'h0240 + ((i + 16) % 64)],
            8'(i) ^ 8'h5A);
    check(eec_dev_model_i.mem[15'h0280], 8'h43);
  endtask : t_page

  // Random read of four bytes, then a current read after it
  task automatic t_rand();
    run(OP_READ_RAND, 2'h2, 16'h1234, 7'h03);
    check(rq.size(), 16'h0004);
    for (int i = 0; i < 4; i++) check(rq[i], 8'(8'h34 + i) ^ 8'hC3);
    run(OP_READ_CUR, 2'h2, 16'h0000, 7'h00);
    check(rq[0], 8'h38 ^ 8'hC3);
    run(OP_READ_RAND, 2'h2, 16'h7FFF, 7'h01);
    check(rq[0], 8'h3C);
    check(rq[1], 8'hC3);
  endtask : t_rand

  // Wrong strap select is left unanswered
  task automatic t_miss();
    run(OP_READ_CUR, 2'h1, 16'h0000, 7'h00);
    check(status.nack, 16'h0001);
  endtask : t_miss

  // Program cycle longer than the poll limit
  task automatic t_tmo();
    prog_ns = 16'hFFFF;
    wq.push_back(8'hA5);
    run(OP_WRITE, 2'h2, 16'h0005, 7'h00);
    check(status.timeout, 16'h0001);
    check(eec_dev_model_i.mem[15'h0005], 8'hA5);
    for (int k = 0; k < 20000 && eec_dev_model_i.busy; k++) @(negedge clk);
    prog_ns = 16'd3000;
  endtask : t_tmo

  // Bus recovery: stuck-low line times out, idle line recovers
  task automatic t_recov();
    stuck = 1'b1;
    run(OP_RECOVER, 2'h2, 16'h0000, 7'h00);
    check(status.timeout, 16'h0001);
    stuck = 1'b0;
    run(OP_RECOVER, 2'h2, 16'h0000, 7'h00);
    check(status, 16'h0000);
    check({scl, sda_oe_n}, 16'h0003);
  endtask : t_recov

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end

  // Reset, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    strap = 2'h2;
    stuck = 1'b0;
    prog_ns = 16'd3000;
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    check({scl, sda_oe_n, wp, cmd_ready}, 16'h000F);
    t_page();
    t_rand();
    t_miss();
    t_tmo();
    t_recov();
    results();
  end

  // Watchdog for a hung transfer
  initial begin
    #300000;
    miscompares++;
    results();
  end
endmodule : tb_top
